// >>> src/adc_ctrl_consts.svh
// register indices, field positions, reset values and codes of the converter control
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_CTRL_ONE 8'he1
`define IDX_CTRL_ZERO 8'he8
`define IDX_DELAY_HIGH 8'he2
`define IDX_DELAY_LOW 8'he3
`define IDX_RESULT_HIGH 8'hc3
`define IDX_RESULT_LOW 8'hc2
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define C0_DONE 7
`define C0_BUSY 6
`define C0_SRC_HI 5
`define C0_SRC_LO 4
`define C0_CH_HI 3
`define C0_CH_LO 0
`define C1_PINLOC 6
`define C1_TYPE_HI 3
`define C1_TYPE_LO 2
`define C1_HWEN 1
`define C1_PWR 0
`define DLY_MSB 8
// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_DELAY 9'h000
`define RST_RESULT 12'h000
`define SRC_CH_ZERO 2'b00
`define SRC_CH_TWO 2'b01
`define SRC_CH_FOUR 2'b10
`define SRC_PIN 2'b11
`define TYP_FALL 2'b00
`define TYP_RISE 2'b01
`define TYP_CENTRE 2'b10
`define TYP_END 2'b11
`define CH_BANDGAP 4'h8
`endif

// >>> src/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;
  // trigger inputs from the pulse modulator
  typedef struct packed {
    logic centre_aligned;
    logic centre_point;
    logic period_end;
    logic [2:0] level;
  } pwm_trig_t;
  // controls toward the analog converter
  typedef struct packed {
    logic power_on;
    logic start;
    logic [8:0] input_connect;
  } conv_ctl_t;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;
endpackage : adc_ctrl_pkg

// >>> src/adc_conversion_control.sv
// converter control: apb registers, start sources, trigger delay and done flag
//
// Behaviour
// - done flag sets at conversion end, stays until software writes zero
// - while done flag is one, no new conversion may begin
// - writing one to start bit begins conversion; writing zero does nothing
// - start bit reads one while converting, zero idle; cleared on completion
// - source field picks pulse channel zero, two, four or external pin
// - channel codes 0-7 pick analog inputs, 8 band-gap, rest reserved
// - power bit turns converter on; off disconnects every analog input
// - pin location bit routes external start to P0.4 or P1.3 at once
// - type field: falling, rising, period centre, period end
// - centre and end conditions exist only with centre-aligned modulator
// - hardware enable zero: software start only; one: software or trigger
// - triggers during a conversion are dropped silently until busy clears
// - accepted trigger sets the start bit like a software start
// - completion clears start, sets done, flags interrupt, stores result
// - after a trigger, wait nine-bit count of converter clocks, then convert
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"

module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CLK_DIV = 4,
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pwm_trig_t pwm_in,
  input wire logic start_pin_p04,
  input wire logic start_pin_p13,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output conv_ctl_t conv_ctl,
  output logic conversion_done_flag
);

  localparam int PRE_W = (CONV_CLK_DIV > 1) ? $clog2(CONV_CLK_DIV) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CONV_CLK_DIV - 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (CONV_CLK_DIV < 1 || CONV_CLK_DIV > 256) begin : g_bad_div
      $error("converter clock divider out of range");
    end
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
      $error("address width cannot hold the register indices");
    end
  endgenerate

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // word-aligned index match, upper address bits must be clear
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    logic [ADDR_W-1:0] base;
    base = '0;
    base[9:2] = idx;
    reg_hit = (a == base);
  endfunction : reg_hit

  // one-hot input connect; reserved codes and power-off connect nothing
  function automatic logic [8:0] chan_decode(input logic [3:0] code, input logic on);
    logic [8:0] sel;
    sel = '0;
    if (on && code <= `CH_BANDGAP) begin
      sel[code] = 1'b1;
    end
    chan_decode = sel;
  endfunction : chan_decode

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0] src_r;
  logic [3:0] chan_r;
  logic pinloc_r;
  logic [1:0] type_r;
  logic hwen_r;
  logic pwr_r;
  logic done_r;
  logic done_nxt;
  logic [8:0] dly_r;
  logic [11:0] res_r;
  logic [31:0] prdata_r;
  logic start_r;
  logic start_nxt;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [2:0] pwm_prev_r;
  logic pin_prev_r;
  logic [2:0] pin_sync_r [2];
  logic [1:0] pin_stable_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_c0 = reg_hit(paddr, `IDX_CTRL_ZERO);
  wire hit_c1 = reg_hit(paddr, `IDX_CTRL_ONE);
  wire hit_dh = reg_hit(paddr, `IDX_DELAY_HIGH);
  wire hit_dl = reg_hit(paddr, `IDX_DELAY_LOW);
  wire hit_rh = reg_hit(paddr, `IDX_RESULT_HIGH);
  wire hit_rl = reg_hit(paddr, `IDX_RESULT_LOW);
  wire mapped = hit_c0 | hit_c1 | hit_dh | hit_dl | hit_rh | hit_rl;
  wire wr_c0 = wr & hit_c0;
  wire wr_c1 = wr & hit_c1;
  wire wr_dh = wr & hit_dh;
  wire wr_dl = wr & hit_dl;

  // no wait state: read data is captured in setup, answered in access
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_r;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire busy = (state_r != ST_IDLE);
  wire [7:0] rd_c0 = {done_r, busy, src_r, chan_r};
  wire [7:0] rd_c1 = {1'b0, pinloc_r, 2'b00, type_r, hwen_r, pwr_r};
  wire [7:0] rd_dh = {7'h00, dly_r[`DLY_MSB]};
  wire [7:0] rd_dl = dly_r[7:0];
  wire [7:0] rd_rh = res_r[11:4];
  wire [7:0] rd_rl = {4'h0, res_r[3:0]};
  wire [7:0] rd_byte = hit_c0 ? rd_c0 :
                       hit_c1 ? rd_c1 :
                       hit_dh ? rd_dh :
                       hit_dl ? rd_dl :
                       hit_rh ? rd_rh :
                       hit_rl ? rd_rl : 8'h00;

  // ---------------------------------------------------------------
  // external start pins
  // ---------------------------------------------------------------
  // three-stage synchroniser; the level moves once stages two and three agree
  wire [1:0] pin_raw = {start_pin_p13, start_pin_p04};
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          pin_sync_r[g] <= 3'b000;
          pin_stable_r[g] <= 1'b0;
        end else begin
          pin_sync_r[g] <= {pin_sync_r[g][1:0], pin_raw[g]};
          if (pin_sync_r[g][1] == pin_sync_r[g][2]) begin
            pin_stable_r[g] <= pin_sync_r[g][2];
          end
        end
      end
    end
  endgenerate

  // both pins are tracked so a location switch needs no resync; it can
  // however look like an edge when the two pins differ
  wire pin_cur = pinloc_r ? pin_stable_r[1] : pin_stable_r[0];

  // ---------------------------------------------------------------
  // trigger condition
  // ---------------------------------------------------------------
  wire src_is_pin = (src_r == `SRC_PIN);
  wire trig_cur = (src_r == `SRC_CH_ZERO) ? pwm_in.level[0] :
                  (src_r == `SRC_CH_TWO) ? pwm_in.level[1] :
                  (src_r == `SRC_CH_FOUR) ? pwm_in.level[2] : pin_cur;
  wire trig_prev = (src_r == `SRC_CH_ZERO) ? pwm_prev_r[0] :
                   (src_r == `SRC_CH_TWO) ? pwm_prev_r[1] :
                   (src_r == `SRC_CH_FOUR) ? pwm_prev_r[2] : pin_prev_r;
  wire edge_fall = trig_prev & ~trig_cur;
  wire edge_rise = ~trig_prev & trig_cur;
  // period points only from a centre-aligned modulator channel
  wire pwm_pts = ~src_is_pin & pwm_in.centre_aligned;
  wire pt_centre = pwm_pts & pwm_in.centre_point;
  wire pt_end = pwm_pts & pwm_in.period_end;
  wire hw_cond = (type_r == `TYP_FALL) ? edge_fall :
                 (type_r == `TYP_RISE) ? edge_rise :
                 (type_r == `TYP_CENTRE) ? pt_centre : pt_end;

  // ---------------------------------------------------------------
  // start arbitration
  // ---------------------------------------------------------------
  // a start needs an idle, powered converter and a clear done flag
  wire can_start = ~busy & ~done_r & pwr_r;
  wire sw_req = wr_c0 & pwdata[`C0_BUSY];
  wire take_sw = sw_req & can_start;
  wire take_hw = hwen_r & hw_cond & can_start & ~sw_req;
  wire done_evt = (state_r == ST_CONV) & conv_done;
  wire tick = (pre_r == PRE_LAST);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    start_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (take_sw) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
        end else if (take_hw) begin
          state_nxt = ST_DELAY;
          cnt_nxt = dly_r;
        end
      end
      ST_DELAY: begin
        if (cnt_r == 9'h000) begin
          state_nxt = ST_CONV;
          start_nxt = 1'b1;
        end else if (tick) begin
          cnt_nxt = cnt_r - 9'h001;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // powering down abandons any conversion without a result
    if (!pwr_r) begin
      state_nxt = ST_IDLE;
      start_nxt = 1'b0;
    end
  end

  // converter clock prescaler, restarted at each delay phase
  assign pre_nxt = (state_r != ST_DELAY || tick) ? '0 : pre_r + PRE_W'(1);

  // hardware set wins over a software clear in the same cycle
  assign done_nxt = done_evt ? 1'b1 :
                    wr_c0 ? pwdata[`C0_DONE] : done_r;

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= `RST_DELAY;
      pre_r <= '0;
      start_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      start_r <= start_nxt;
      done_r <= done_nxt;
    end
  end

  // previous levels for edge detection
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwm_prev_r <= 3'b000;
      pin_prev_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_in.level;
      pin_prev_r <= pin_cur;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // configuration fields; the start bit is not stored, it is the busy state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      src_r <= 2'b00;
      chan_r <= 4'h0;
      pinloc_r <= 1'b0;
      type_r <= 2'b00;
      hwen_r <= 1'b0;
      pwr_r <= 1'b0;
      dly_r <= `RST_DELAY;
    end else begin
      if (wr_c0) begin
        src_r <= pwdata[`C0_SRC_HI:`C0_SRC_LO];
        chan_r <= pwdata[`C0_CH_HI:`C0_CH_LO];
      end
      if (wr_c1) begin
        pinloc_r <= pwdata[`C1_PINLOC];
        type_r <= pwdata[`C1_TYPE_HI:`C1_TYPE_LO];
        hwen_r <= pwdata[`C1_HWEN];
        pwr_r <= pwdata[`C1_PWR];
      end
      if (wr_dh) begin
        dly_r[`DLY_MSB] <= pwdata[0];
      end
      if (wr_dl) begin
        dly_r[7:0] <= pwdata[7:0];
      end
    end
  end

  // result capture and bus read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      res_r <= `RST_RESULT;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (done_evt) begin
        res_r <= conv_result;
      end
      if (setup) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------
  // converter controls
  // ---------------------------------------------------------------
  assign conv_ctl.power_on = pwr_r;
  assign conv_ctl.start = start_r;
  assign conv_ctl.input_connect = chan_decode(chan_r, pwr_r);
  // the flag doubles as the interrupt request; enabling is elsewhere
  assign conversion_done_flag = done_r;

endmodule : adc_conversion_control

// >>> dv/adc_ctrl_monitor.sv
// port checker for the converter control block
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"
module adc_ctrl_monitor
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pwm_trig_t pwm_in,
  input wire logic start_pin_p04,
  input wire logic start_pin_p13,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  input wire conv_ctl_t conv_ctl,
  input wire logic conversion_done_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // write decode for the two control words
  wire acc = psel && penable && pwrite;
  wire wr0 = acc && paddr == ADDR_W'({`IDX_CTRL_ZERO, 2'b00});
  wire wr1 = acc && paddr == ADDR_W'({`IDX_CTRL_ONE, 2'b00});
  // completion racing a clearing write
  sequence s_clr_race;
    wr0 && !pwdata[7] && conv_done && conv_ctl.power_on;
  endsequence
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("ready missing in access");
  a_err_scope: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_start_single: assert property (conv_ctl.start |=> !conv_ctl.start)
    else $error("start pulse too long");
  a_power_isolate: assert property (!conv_ctl.power_on |-> conv_ctl.input_connect == '0)
    else $error("input connected while off");
  a_route_onehot: assert property ($onehot0(conv_ctl.input_connect))
    else $error("several inputs connected");
  a_done_sets: assert property (conv_done && conv_ctl.power_on |=> conversion_done_flag)
    else $error("done flag not set");
  a_flag_sticky: assert property (conversion_done_flag && !wr0 |=> conversion_done_flag)
    else $error("done flag lost");
  a_set_priority: assert property (s_clr_race |=> conversion_done_flag)
    else $error("completion lost to clear");
  a_refuse_done: assert property (wr0 && pwdata[6] && conversion_done_flag |=> !conv_ctl.start)
    else $error("start while done");
  a_zero_nostart: assert property (wr0 && !pwdata[6] |=> !conv_ctl.start)
    else $error("zero write started");
  a_power_follow: assert property (wr1 |=> conv_ctl.power_on == $past(pwdata[0]))
    else $error("power bit not applied");
endmodule : adc_ctrl_monitor

bind adc_conversion_control adc_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_in(pwm_in), .start_pin_p04(start_pin_p04), .start_pin_p13(start_pin_p13),
  .conv_done(conv_done), .conv_result(conv_result), .conv_ctl(conv_ctl),
  .conversion_done_flag(conversion_done_flag)
);

// >>> dv/adc_conv_model.sv
// behavioural converter answering start pulses after a fixed latency
`timescale 1ns/10ps
module adc_conv_model
  import adc_ctrl_pkg::*;
#(
  parameter int LAT = 20,
  parameter logic [11:0] RES = 12'ha5c
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire conv_ctl_t conv_ctl,
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic [7:0] cnt_r;
  // power loss aborts; result bus scrambles outside the done pulse
  always_ff @(posedge mclk) begin
    if (!rstn || !conv_ctl.power_on)
      cnt_r <= 8'h00;
    else if (conv_ctl.start)
      cnt_r <= 8'(LAT);
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    conv_done <= rstn && conv_ctl.power_on && cnt_r == 8'h01;
    conv_result <= (cnt_r == 8'h01 || !rstn) ? RES : ~conv_result;
  end
endmodule : adc_conv_model

// >>> dv/tb_adc_conversion_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb_adc_conversion_control;
  import adc_ctrl_pkg::*;
  localparam int LAT = 20;
  localparam logic [11:0] RES = 12'ha5c;
  localparam logic [11:0] A0 = 12'h3a0, A1 = 12'h384, ADL = 12'h38c;
  localparam logic [11:0] ARH = 12'h30c, ARL = 12'h308;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, conv_done, conversion_done_flag;
  logic start_pin_p04 = 0, start_pin_p13 = 0;
  logic [11:0] conv_result;
  pwm_trig_t pwm_in = '0;
  conv_ctl_t conv_ctl;
  int fail_count = 0, checks = 0, starts = 0, base = 0;

  always #2 mclk = ~mclk;
  // count start pulses sent to the converter
  always @(posedge mclk) if (conv_ctl.start === 1'b1) starts++;

  adc_conversion_control #(.CONV_CLK_DIV(1), .ADDR_W(12)) DUT (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_in(pwm_in), .start_pin_p04(start_pin_p04), .start_pin_p13(start_pin_p13),
    .conv_done(conv_done), .conv_result(conv_result), .conv_ctl(conv_ctl),
    .conversion_done_flag(conversion_done_flag));
  adc_conv_model #(.LAT(LAT), .RES(RES)) u_conv (.mclk(mclk), .rstn(rstn),
    .conv_ctl(conv_ctl), .conv_done(conv_done), .conv_result(conv_result));

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; an idle edge first so psel never toggles twice at once
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no own limit: a missing answer is left to the watchdog
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, exp}, rd);
  endtask : rdchk
  // watch a window for starts, then clear the done flag
  task conv(input int e, input logic [7:0] c0);
    int s0;
    s0 = starts;
    repeat (40) @(posedge mclk);
    chk("starts", e, starts - s0);
    if (e != 0) chk("flag", 1, conversion_done_flag);
    apb(1'b1, A0, c0);
  endtask : conv
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // watchdog far beyond the expected run of about a thousand cycles
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rdchk("ctrl0", A0, 8'h00);
    rdchk("ctrl1", A1, 8'h00);
    rdchk("delay", ADL, 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    chk("slverr", 1, err);
    apb(1'b1, A1, 8'h4d);
    rdchk("ctrl1", A1, 8'h4d);
    $display("test registers done");
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, A0, 8'(c));
      @(negedge mclk);
      chk("route", (c < 9) ? (1 << c) : 0, conv_ctl.input_connect);
    end
    apb(1'b1, A0, 8'h03);
    apb(1'b1, A1, 8'h00);
    @(negedge mclk);
    chk("isolate", 0, conv_ctl.input_connect);
    $display("test routing done");
    apb(1'b1, A1, 8'h01);
    apb(1'b1, A0, 8'h01);
    rdchk("idle", A0, 8'h01);
    apb(1'b1, A0, 8'h41);
    rdchk("busy", A0, 8'h41);
    for (int n = 0; n < 60 && conversion_done_flag !== 1'b1; n++) @(posedge mclk);
    rdchk("done", A0, 8'h81);
    rdchk("res hi", ARH, RES[11:4]);
    rdchk("res lo", ARL, {4'h0, RES[3:0]});
    apb(1'b1, A0, 8'hc1);
    conv(0, 8'h01);
    rdchk("cleared", A0, 8'h01);
    apb(1'b1, A0, 8'h41);
    @(posedge mclk iff conv_ctl.start === 1'b1);
    repeat (LAT - 2) @(posedge mclk);
    apb(1'b1, A0, 8'h01);
    rdchk("kept", A0, 8'h81);
    apb(1'b1, A0, 8'h01);
    $display("test software start done");
    apb(1'b1, A1, 8'h05);
    pwm_in.level[0] <= 1'b1;
    conv(0, 8'h00);
    pwm_in.level[0] <= 1'b0;
    apb(1'b1, A1, 8'h07);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, A0, 8'(s << 4));
      pwm_in.level <= 3'b111 ^ (3'b001 << s);
      conv(0, 8'(s << 4));
      // the window opens before the pulse so the accepted start is counted
      fork
        conv(1, 8'(s << 4));
        begin
          pwm_in.level[s] <= 1'b1;
          repeat (3) @(posedge mclk);
          pwm_in.level[s] <= 1'b0;
          @(posedge mclk);
          pwm_in.level[s] <= 1'b1;
        end
      join
      pwm_in.level <= 3'b000;
    end
    pwm_in.centre_aligned <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, A1, 8'(3 + 4 * t));
      apb(1'b1, A0, 8'h00);
      pwm_in.level[0] <= (t == 0);
      @(posedge mclk);
      pwm_in.level[0] <= (t == 1);
      pwm_in.centre_point <= (t == 2);
      pwm_in.period_end <= (t == 3);
      @(posedge mclk);
      pwm_in.centre_point <= 1'b0;
      pwm_in.period_end <= 1'b0;
      conv(1, 8'h00);
      pwm_in.level[0] <= 1'b0;
    end
    $display("test pulse triggers done");
    apb(1'b1, A1, 8'h07);
    apb(1'b1, A0, 8'h30);
    start_pin_p13 <= 1'b1;
    conv(0, 8'h30);
    start_pin_p04 <= 1'b1;
    conv(1, 8'h30);
    apb(1'b1, A1, 8'h47);
    start_pin_p13 <= 1'b0;
    repeat (8) @(posedge mclk);
    start_pin_p13 <= 1'b1;
    conv(1, 8'h30);
    $display("test pin triggers done");
    apb(1'b1, ADL, 8'h14);
    rdchk("delay", ADL, 8'h14);
    apb(1'b1, A1, 8'h07);
    apb(1'b1, A0, 8'h00);
    base = starts;
    pwm_in.level[0] <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("early", 0, starts - base);
    conv(1, 8'h00);
    $display("test trigger delay done");
    give_verdict();
  end
endmodule : tb_adc_conversion_control
